// file: design/bcc_map.svh
/*
   Register map, field positions, reset values and timing counts of the
   base timer capture/compare group.
   Assumes a 32-bit APB slave port with an 8-bit byte address.
*/
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// =====================================================================
// Address decode: region in paddr[7:5], word index in paddr[4:2]
`define BCC_REGION_SCALAR   3'h0
`define BCC_REGION_CAPCFG   3'h1
`define BCC_REGION_CAPVAL   3'h2
`define BCC_REGION_CMPVAL   3'h3
`define BCC_IDX_CTRL        3'h0
`define BCC_IDX_TIMER       3'h1
`define BCC_IDX_STATUS      3'h2
`define BCC_IDX_MASK        3'h3
`define BCC_IDX_CMPMODE     3'h4

// =====================================================================
// Control register fields
`define BCC_CTRL_GSTART     0
`define BCC_CTRL_CSTART     1
`define BCC_CTRL_RSTSRC_LO  2
`define BCC_CTRL_PINSEL     4
`define BCC_CTRL_CNTSRC     5
`define BCC_CTRL_W          6

// Capture channel configuration fields
`define BCC_CAP_EDGE_LO     0
`define BCC_CAP_FILT_EN     2
`define BCC_CAP_FILT_TICK   3
`define BCC_CAP_PRE_EN      4
`define BCC_CAP_PRE_LO      8

// Compare mode nibble fields, four bits per channel
`define BCC_CMP_MODE_LO     0
`define BCC_CMP_INV         2
`define BCC_CMP_DEFAULT     3
`define BCC_CMP_NIBBLE      4

// Status and mask layout: captures low byte, compare matches next byte
`define BCC_STAT_CAP_LO     0
`define BCC_STAT_CMP_LO     8

// =====================================================================
// Sizes, reset values and timing counts
`define BCC_CAP_CHANNELS    8
`define BCC_CMP_CHANNELS    8
`define BCC_STATE_RESET     '0
`define BCC_TIMER_ZERO      16'h0000
`define BCC_FILTER_AGREE    3'h7
`define BCC_FILTER_NONE     3'h0
`define BCC_CMP0_RST_CLOCKS 2

`endif

// file: design/bcc_pkg.sv
/*
   Types of the base timer capture/compare group: modes, sources and the
   packed state records of the group and of one capture channel.
   Assumes bcc_map.svh for sizes.
*/
`include "bcc_map.svh"

package bcc_pkg;

   // ==================================================================
   // Modes and sources
   typedef enum logic [1:0] {
      BCC_RST_OVF   = 2'h0,
      BCC_RST_CMP0  = 2'h1,
      BCC_RST_PIN   = 2'h2,
      BCC_RST_GROUP = 2'h3
   } bcc_rst_src_t;

   typedef enum logic [1:0] {
      BCC_EDGE_OFF  = 2'h0,
      BCC_EDGE_RISE = 2'h1,
      BCC_EDGE_FALL = 2'h2,
      BCC_EDGE_BOTH = 2'h3
   } bcc_edge_t;

   typedef enum logic [1:0] {
      BCC_WAVE_SINGLE = 2'h0,
      BCC_WAVE_INVERT = 2'h1,
      BCC_WAVE_SR     = 2'h2,
      BCC_WAVE_OFF    = 2'h3
   } bcc_wave_mode_t;

   // ==================================================================
   // State records
   typedef struct packed {
      logic [2:0]  samples;
      logic        filtLvl;
      logic        prevLvl;
      logic [7:0]  preCnt;
   } bcc_cap_state_t;

   typedef struct packed {
      logic [31:0]                             prdata;
      logic                                    pready;
      logic                                    pslverr;
      logic                                    irq;
      logic [`BCC_CTRL_W-1:0]                  ctrl;
      logic [15:0]                             status;
      logic [15:0]                             mask;
      logic [31:0]                             cmpMode;
      logic [`BCC_CAP_CHANNELS-1:0][15:0]      capCfg;
      logic [`BCC_CAP_CHANNELS-1:0][15:0]      capVal;
      logic [`BCC_CMP_CHANNELS-1:0][15:0]      cmpVal;
      logic [15:0]                             timer;
      logic                                    phaseAPrev;
      logic                                    cmp0Dly;
      logic [`BCC_CMP_CHANNELS-1:0]            eqPrev;
      logic                                    zeroPrev;
      logic [`BCC_CMP_CHANNELS-1:0]            level;
      logic [`BCC_CMP_CHANNELS-1:0]            waveOut;
   } bcc_state_t;

endpackage

// file: design/bcc_capture_chan.sv
/*
   One capture channel: optional three-sample digital filter, edge
   selection and trigger prescaler. Emits a one-cycle capture strobe.
   Assumes the trigger input is synchronous to clk.
*/
`timescale 1ns/10ps
`include "bcc_map.svh"

module bcc_capture_chan (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             trigIn,
   input  wire logic             countTick,
   input  wire bcc_pkg::bcc_edge_t edgeSel,
   input  wire logic             filtEn,
   input  wire logic             filtOnTick,
   input  wire logic             preEn,
   input  wire logic [7:0]       preVal,
   output logic                  captureStrobe
);
   import bcc_pkg::*;

   bcc_cap_state_t s;
   bcc_cap_state_t n;
   logic           lvl;
   logic           edgeHit;

   // ==================================================================
   // Filter, edge and prescaler
   always_comb begin
      n = s;
      if (!filtOnTick || countTick) begin
         n.samples = {s.samples[1:0], trigIn};
      end
      if (s.samples == `BCC_FILTER_AGREE) begin
         n.filtLvl = 1'b1;
      end else if (s.samples == `BCC_FILTER_NONE) begin
         n.filtLvl = 1'b0;
      end
      lvl = filtEn ? s.filtLvl : trigIn;
      n.prevLvl = lvl;
      unique case (edgeSel)
         BCC_EDGE_RISE: edgeHit = lvl & ~s.prevLvl;
         BCC_EDGE_FALL: edgeHit = ~lvl & s.prevLvl;
         BCC_EDGE_BOTH: edgeHit = lvl ^ s.prevLvl;
         BCC_EDGE_OFF:  edgeHit = 1'b0;
      endcase
      captureStrobe = edgeHit & (~preEn | (s.preCnt == 8'h00));
      if (!preEn) begin
         n.preCnt = 8'h00;
      end else if (edgeHit) begin
         n.preCnt = (s.preCnt == 8'h00) ? preVal : s.preCnt - 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= `BCC_STATE_RESET;
      end else begin
         s <= n;
      end
   end

   // ==================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_filter_agree: assert property ($changed(s.filtLvl) |->
      ($past(s.samples) == `BCC_FILTER_AGREE || $past(s.samples) == `BCC_FILTER_NONE))
      else $error("filter output changed without three agreeing samples");
   a_prescale_reload: assert property (captureStrobe && preEn |=>
      s.preCnt == $past(preVal))
      else $error("prescaler not reloaded after a capture");

   c_filter_change: cover property (filtEn && $rose(s.filtLvl));
   c_prescaled_cap: cover property (preEn && preVal != 8'h00 && captureStrobe);

endmodule // bcc_capture_chan

// file: design/bcc_timer_group.sv
/*
   Base timer capture/compare group: 16-bit free-running base timer,
   eight capture channels, eight compare channels with waveform outputs,
   event flags with mask and interrupt, APB register slave.
   Assumes all inputs synchronous to clk; other groups drive
   otherGroupReset as a pulse or level on this clock.
*/
// The address map and register access over APB were decided locally.
// Behaviour
// - The base timer is a 16-bit counter that runs freely unless a chosen reset clears it.
// - The timer counts on the undivided clock or on a two-phase pulse input, chosen by software.
// - Software chooses the timer reset source: overflow, compare 0 match or a low pin level.
// - For the pin reset, software picks one of two external interrupt pins.
// - A reset request from another timer group is a further selectable reset source.
// - The timer is held at zero while both the group and the common start bits are 0.
// - Each accepted capture trigger copies the current timer value into that channel's register.
// - Each compare channel except one in off mode or an odd one in set-reset mode changes its waveform when the timer equals its compare value.
// - The group has eight compare channels with single-phase, inverted and set-reset modes.
// - The group stays within 32 capture and 32 compare channels, with its own base timer.
// - With filtering on, a trigger level passes only after three agreeing samples.
// - Single-phase output goes high on a match and low when the timer returns to zero.
// - With compare 0 as reset source, the timer reads zero two clocks after the match.
// - With the prescaler on, a capture is stored once per programmed count plus one triggers.
`timescale 1ns/10ps
`include "bcc_map.svh"

module bcc_timer_group (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [7:0]    paddr,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [7:0]    trigIn,
   input  wire logic          phaseA,
   input  wire logic          phaseB,
   input  wire logic          extIrqPinA,
   input  wire logic          extIrqPinB,
   input  wire logic          otherGroupReset,
   output logic [7:0]         waveOut,
   output logic               irq
);
   import bcc_pkg::*;

   bcc_state_t                    s;
   bcc_state_t                    n;
   logic [31:0]                   rdata;
   logic                          hit;
   logic [31:0]                   wmask;
   logic [31:0]                   merged;
   logic                          setupPhase;
   logic                          accessDone;
   logic                          groupTimerStartBit;
   logic                          commonTimerStartBit;
   logic                          running;
   logic                          baseTimerCountClock;
   logic                          pinLow;
   bcc_rst_src_t                  rstSrc;
   logic [`BCC_CMP_CHANNELS-1:0]  eqNow;
   logic [`BCC_CMP_CHANNELS-1:0]  cmpEvt;
   logic                          zeroEvt;
   logic [`BCC_CAP_CHANNELS-1:0]  capStrobe;
   logic [15:0]                   flagSet;
   logic [15:0]                   flagClr;
   bcc_wave_mode_t                wmode;
   logic [15:0]                   statusCur;

   // ==================================================================
   // Control decode
   assign groupTimerStartBit  = s.ctrl[`BCC_CTRL_GSTART];
   assign commonTimerStartBit = s.ctrl[`BCC_CTRL_CSTART];
   assign running  = groupTimerStartBit | commonTimerStartBit;
   assign rstSrc   = bcc_rst_src_t'(s.ctrl[`BCC_CTRL_RSTSRC_LO +: 2]);
   assign pinLow   = s.ctrl[`BCC_CTRL_PINSEL] ? ~extIrqPinB : ~extIrqPinA;
   assign baseTimerCountClock = s.ctrl[`BCC_CTRL_CNTSRC] ?
                                (phaseA & ~s.phaseAPrev) : 1'b1;

   // ==================================================================
   // Capture channels
   genvar gc;
   generate
      for (gc = 0; gc < `BCC_CAP_CHANNELS; gc++) begin : g_cap
         bcc_capture_chan u_cap (
            .clk           (clk),
            .rst           (rst),
            .trigIn        (trigIn[gc]),
            .countTick     (baseTimerCountClock),
            .edgeSel       (bcc_edge_t'(s.capCfg[gc][`BCC_CAP_EDGE_LO +: 2])),
            .filtEn        (s.capCfg[gc][`BCC_CAP_FILT_EN]),
            .filtOnTick    (s.capCfg[gc][`BCC_CAP_FILT_TICK]),
            .preEn         (s.capCfg[gc][`BCC_CAP_PRE_EN]),
            .preVal        (s.capCfg[gc][`BCC_CAP_PRE_LO +: 8]),
            .captureStrobe (capStrobe[gc])
         );
      end
   endgenerate

   // ==================================================================
   // Register read decode
   always_comb begin
      rdata = 32'h0000_0000;
      hit   = (paddr[1:0] == 2'h0);
      unique case (paddr[7:5])
         `BCC_REGION_SCALAR: begin
            unique case (paddr[4:2])
               `BCC_IDX_CTRL:    rdata = {26'h000_0000, s.ctrl};
               `BCC_IDX_TIMER:   rdata = {16'h0000, s.timer};
               `BCC_IDX_STATUS:  rdata = {16'h0000, s.status};
               `BCC_IDX_MASK:    rdata = {16'h0000, s.mask};
               `BCC_IDX_CMPMODE: rdata = s.cmpMode;
               default:          hit   = 1'b0;
            endcase
         end
         `BCC_REGION_CAPCFG: rdata = {16'h0000, s.capCfg[paddr[4:2]]};
         `BCC_REGION_CAPVAL: rdata = {16'h0000, s.capVal[paddr[4:2]]};
         `BCC_REGION_CMPVAL: rdata = {16'h0000, s.cmpVal[paddr[4:2]]};
         default:            hit   = 1'b0;
      endcase
   end

   assign wmask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign merged = (rdata & ~wmask) | (pwdata & wmask);
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & s.pready;

   // ==================================================================
   // Next state
   always_comb begin
      n = s;
      wmode = BCC_WAVE_SINGLE;

      // APB: one access cycle after setup, data and error prepared at setup
      n.pready = setupPhase;
      if (setupPhase) begin
         n.prdata  = hit ? rdata : 32'h0000_0000;
         n.pslverr = ~hit;
      end else begin
         n.pslverr = 1'b0;
      end

      // Match and zero events
      for (int k = 0; k < `BCC_CMP_CHANNELS; k++) begin
         eqNow[k] = (s.timer == s.cmpVal[k]);
      end
      cmpEvt  = eqNow & ~s.eqPrev & {`BCC_CMP_CHANNELS{running}};
      zeroEvt = (s.timer == `BCC_TIMER_ZERO) & ~s.zeroPrev & running;
      n.eqPrev     = eqNow;
      n.zeroPrev   = (s.timer == `BCC_TIMER_ZERO);
      n.phaseAPrev = phaseA;
      n.cmp0Dly    = cmpEvt[0] & (rstSrc == BCC_RST_CMP0);

      // Base timer
      if (!running) begin
         n.timer = `BCC_TIMER_ZERO;
      end else if (rstSrc == BCC_RST_PIN && pinLow) begin
         n.timer = `BCC_TIMER_ZERO;
      end else if (rstSrc == BCC_RST_GROUP && otherGroupReset) begin
         n.timer = `BCC_TIMER_ZERO;
      end else if (s.cmp0Dly) begin
         n.timer = `BCC_TIMER_ZERO;
      end else if (baseTimerCountClock) begin
         if (s.ctrl[`BCC_CTRL_CNTSRC] && phaseB) begin
            n.timer = s.timer - 16'h0001;
         end else begin
            n.timer = s.timer + 16'h0001;
         end
      end

      // Captures
      for (int j = 0; j < `BCC_CAP_CHANNELS; j++) begin
         if (capStrobe[j]) begin
            n.capVal[j] = s.timer;
         end
      end

      // Waveform outputs
      for (int k = 0; k < `BCC_CMP_CHANNELS; k++) begin
         wmode = bcc_wave_mode_t'(s.cmpMode[k*`BCC_CMP_NIBBLE + `BCC_CMP_MODE_LO +: 2]);
         if (!running) begin
            n.level[k] = s.cmpMode[k*`BCC_CMP_NIBBLE + `BCC_CMP_DEFAULT];
         end else begin
            unique case (wmode)
               BCC_WAVE_SINGLE: begin
                  if (cmpEvt[k]) begin
                     n.level[k] = 1'b1;
                  end else if (zeroEvt) begin
                     n.level[k] = 1'b0;
                  end
               end
               BCC_WAVE_INVERT: begin
                  if (cmpEvt[k]) begin
                     n.level[k] = ~s.level[k];
                  end
               end
               BCC_WAVE_SR: begin
                  if (k % 2 == 0) begin
                     if (cmpEvt[k]) begin
                        n.level[k] = 1'b1;
                     end else if (cmpEvt[k | 1] || zeroEvt) begin
                        n.level[k] = 1'b0;
                     end
                  end
               end
               BCC_WAVE_OFF: n.level[k] = s.level[k];
            endcase
         end
         n.waveOut[k] = n.level[k] ^ s.cmpMode[k*`BCC_CMP_NIBBLE + `BCC_CMP_INV];
      end

      // Register writes, taken at the completing access edge
      flagClr = 16'h0000;
      if (accessDone && pwrite && hit) begin
         unique case (paddr[7:5])
            `BCC_REGION_SCALAR: begin
               unique case (paddr[4:2])
                  `BCC_IDX_CTRL:    n.ctrl    = merged[`BCC_CTRL_W-1:0];
                  `BCC_IDX_STATUS:  flagClr   = pwdata[15:0] & wmask[15:0];
                  `BCC_IDX_MASK:    n.mask    = merged[15:0];
                  `BCC_IDX_CMPMODE: n.cmpMode = merged;
                  default:          n.ctrl    = s.ctrl;
               endcase
            end
            `BCC_REGION_CAPCFG: n.capCfg[paddr[4:2]] = merged[15:0];
            `BCC_REGION_CMPVAL: n.cmpVal[paddr[4:2]] = merged[15:0];
            default:            n.ctrl = s.ctrl;
         endcase
      end

      // Sticky flags: a new event wins over a clear in the same cycle
      flagSet  = {cmpEvt, capStrobe};
      n.status = (s.status & ~flagClr) | flagSet;
      n.irq    = |(n.status & n.mask);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= `BCC_STATE_RESET;
      end else begin
         s <= n;
      end
   end

   assign prdata  = s.prdata;
   assign pready  = s.pready;
   assign pslverr = s.pslverr;
   assign waveOut = s.waveOut;
   assign irq     = s.irq;
   assign statusCur = s.status;

   // ==================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_hold_stopped: assert property (!running |=> s.timer == `BCC_TIMER_ZERO)
      else $error("timer not held at zero while stopped");
   a_free_count: assert property (running && !s.ctrl[`BCC_CTRL_CNTSRC] &&
      rstSrc == BCC_RST_OVF && $stable(s.ctrl) |=> s.timer == $past(s.timer) + 16'h0001)
      else $error("timer did not advance by one");
   a_overflow_wrap: assert property (running && s.timer == 16'hffff &&
      baseTimerCountClock && rstSrc == BCC_RST_OVF && !phaseB |=> s.timer == 16'h0000)
      else $error("timer did not wrap to zero");
   a_cmp0_reset: assert property (cmpEvt[0] && rstSrc == BCC_RST_CMP0 ##1
      running && rstSrc == BCC_RST_CMP0 |=> s.timer == `BCC_TIMER_ZERO)
      else $error("timer not zero two clocks after compare 0 match");
   a_pin_reset: assert property (running && rstSrc == BCC_RST_PIN && pinLow
      |=> s.timer == `BCC_TIMER_ZERO)
      else $error("pin reset did not clear timer");
   a_group_reset: assert property (running && rstSrc == BCC_RST_GROUP &&
      otherGroupReset |=> s.timer == `BCC_TIMER_ZERO)
      else $error("group reset did not clear timer");
   a_capture_value: assert property (capStrobe[0] |=> s.capVal[0] == $past(s.timer))
      else $error("capture register does not hold timer value");
   a_match_flag: assert property (cmpEvt[1] |=> statusCur[`BCC_STAT_CMP_LO + 1])
      else $error("compare match flag not set");
   a_single_high: assert property (running && cmpEvt[2] &&
      s.cmpMode[2*`BCC_CMP_NIBBLE +: 2] == 2'h0 ##1 running |-> s.level[2])
      else $error("single-phase output not high after match");
   a_irq_level: assert property (irq == |(statusCur & s.mask))
      else $error("interrupt output disagrees with flags and mask");

   c_cmp0_reset: cover property (s.cmp0Dly && running);
   c_capture: cover property (capStrobe[3] && s.timer != 16'h0000);
   c_sr_high: cover property (s.cmpMode[1:0] == 2'h2 && $rose(s.level[0]));

endmodule // bcc_timer_group

// file: dv/bcc_far_side.sv
/*
   Far side of the timer group: trigger lines, two-phase count input,
   external reset pins and the other-group reset request.
   Assumes the bench calls its tasks right after a rising clk edge.
*/
`timescale 1ns/10ps

module bcc_far_side (
   input  wire logic       clk,
   output logic [7:0]      trigIn,
   output logic            phaseA,
   output logic            phaseB,
   output logic            extIrqPinA,
   output logic            extIrqPinB,
   output logic            otherGroupReset,
   input  wire logic [7:0] waveOut
);
   // =================================================================
   // Idle: pins pulled high, no triggers, no request
   initial begin
      {trigIn, phaseA, phaseB, otherGroupReset} = '0;
      {extIrqPinA, extIrqPinB} = 2'b11;
   end

   task automatic setLines(input logic [7:0] t, input logic a, input logic b, input logic g);
      @(posedge clk);
      trigIn <= t;
      extIrqPinA <= a;
      extIrqPinB <= b;
      otherGroupReset <= g;
   endtask

   // One count pulse; dn selects down counting
   task automatic phaseStep(input logic dn);
      @(posedge clk);
      phaseB <= dn;
      phaseA <= 1'b1;
      @(posedge clk);
      phaseA <= 1'b0;
   endtask
endmodule // bcc_far_side

// file: dv/base_timer_capture_compare_tb.sv
/*
   Self-checking bench of the timer group over APB.
   Assumes the far-side model drives all trigger, pin and phase inputs.
*/
`timescale 1ns/10ps

module base_timer_capture_compare_tb;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rerr, irq;
   logic [7:0]  paddr = '0, trigIn, waveOut;
   logic [31:0] pwdata = '0, prdata, rdat;
   logic [3:0]  pstrb = 4'hf;
   logic        pready, pslverr, phaseA, phaseB, pinA, pinB, grpRst;
   int          errors = 0, totalChecks = 0, cycles = 0;

   always #12.5 clk = ~clk;

   bcc_timer_group dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trigIn(trigIn), .phaseA(phaseA), .phaseB(phaseB),
      .extIrqPinA(pinA), .extIrqPinB(pinB), .otherGroupReset(grpRst), .waveOut(waveOut),
      .irq(irq));
   bcc_far_side far (.clk(clk), .trigIn(trigIn), .phaseA(phaseA), .phaseB(phaseB),
      .extIrqPinA(pinA), .extIrqPinB(pinB), .otherGroupReset(grpRst), .waveOut(waveOut));

   // =================================================================
   // Checking and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_of_test;
      end
   end

   // =================================================================
   // APB master
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask

   // =================================================================
   // Tests
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      apb(1'b0, 8'hfc, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b0, 8'h01, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      $display("test reset_map done");
      wr(8'h00, 32'h21);
      far.phaseStep(1'b1);
      rd(8'h04, 32'hffff);
      repeat (3) far.phaseStep(1'b0);
      rd(8'h04, 32'h2);
      wr(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'hff00);
      wr(8'h08, 32'hff00);
      $display("test two_phase done");
      far.setLines(8'h0, 1'b0, 1'b1, 1'b0);
      wr(8'h20, 32'h1);
      wr(8'h0c, 32'h1);
      wr(8'h00, 32'h0a);
      rd(8'h04, 32'h0);
      far.setLines(8'h0, 1'b1, 1'b1, 1'b0);
      repeat (4) @(posedge clk);
      far.setLines(8'h1, 1'b1, 1'b1, 1'b0);
      rd(8'h40, 32'h5);
      rd(8'h08, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(8'h08, 32'h1);
      rd(8'h08, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(8'h0c, 32'h0);
      far.setLines(8'h0, 1'b1, 1'b1, 1'b0);
      far.setLines(8'h1, 1'b1, 1'b1, 1'b0);
      rd(8'h08, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(8'h08, 32'h1);
      wr(8'h24, 32'h0211);
      far.setLines(8'h3, 1'b1, 1'b1, 1'b0);
      far.setLines(8'h1, 1'b1, 1'b1, 1'b0);
      rd(8'h08, 32'h2);
      wr(8'h08, 32'h2);
      repeat (2) begin
         far.setLines(8'h3, 1'b1, 1'b1, 1'b0);
         far.setLines(8'h1, 1'b1, 1'b1, 1'b0);
      end
      rd(8'h08, 32'h0);
      far.setLines(8'h3, 1'b1, 1'b1, 1'b0);
      far.setLines(8'h1, 1'b1, 1'b1, 1'b0);
      rd(8'h08, 32'h2);
      wr(8'h08, 32'h2);
      $display("test capture done");
      wr(8'h00, 32'h1a);
      far.setLines(8'h1, 1'b1, 1'b0, 1'b0);
      rd(8'h04, 32'h0);
      wr(8'h00, 32'h0e);
      far.setLines(8'h1, 1'b1, 1'b1, 1'b1);
      rd(8'h04, 32'h0);
      far.setLines(8'h1, 1'b1, 1'b1, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      chk({31'h0, rdat != 32'h0}, 32'h1);
      rd(8'h08, 32'hff00);
      wr(8'h08, 32'hff00);
      $display("test reset_sources done");
      wr(8'h00, 32'h0);
      wr(8'h64, 32'h10);
      wr(8'h00, 32'h01);
      repeat (40) @(posedge clk);
      chk({31'h0, waveOut[1]}, 32'h1);
      rd(8'h08, 32'h200);
      wr(8'h08, 32'h200);
      wr(8'h00, 32'h0);
      wr(8'h60, 32'h8);
      wr(8'h00, 32'h05);
      repeat (12) begin
         apb(1'b0, 8'h04, 32'h0);
         chk({31'h0, rdat <= 32'h9}, 32'h1);
      end
      $display("test compare done");
      end_of_test;
   end
endmodule // base_timer_capture_compare_tb
